// file: hw/pdc_pkg.sv
// constants, register map and types for the packet delimiter and collision block
package pdc_pkg;
  localparam int CLK_MHZ = 50;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;

  localparam int CTL_SPEED100 = 0;
  localparam int CTL_FULL_DUP = 1;
  localparam int CTL_LOOPBACK = 2;
  localparam int CTL_COL_TEST = 3;
  localparam int CTL_LED_COL  = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;

  localparam int STA_BAD_SSD = 0;
  localparam int STA_ESD_ERR = 1;
  localparam int STA_COL     = 2;
  localparam int STA_CRS     = 3;
  localparam int STA_RX_PKT  = 4;

  localparam logic [4:0] SYM_I = 5'h1F;
  localparam logic [4:0] SYM_J = 5'h18;
  localparam logic [4:0] SYM_K = 5'h11;
  localparam logic [4:0] SYM_T = 5'h0D;
  localparam logic [4:0] SYM_R = 5'h07;
  localparam logic [9:0] PAIR_II = {SYM_I, SYM_I};
  localparam logic [9:0] PAIR_JK = {SYM_J, SYM_K};
  localparam logic [9:0] PAIR_TR = {SYM_T, SYM_R};

  localparam logic [3:0] RXD_SSD  = 4'h5;
  localparam logic [3:0] RXD_FC   = 4'hE;
  localparam logic [3:0] RXD_ZERO = 4'h0;

  localparam int COL_LED_MS  = 100;
  localparam int COL_LED_CYC = COL_LED_MS * 1000 * CLK_MHZ;
  localparam int SOI_NS      = 200;
  localparam int SOI_CYC     = (SOI_NS * CLK_MHZ) / 1000;

  typedef enum logic [2:0] {TXK_IDLE, TXK_J, TXK_K, TXK_DATA, TXK_T, TXK_R} pdc_txk_t;
  typedef enum logic [1:0] {RX_IDLE, RX_PKT, RX_FALSE, RX_PREM} pdc_rx_t;
endpackage

// file: hw/pdc_sync3.sv
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pdc_sync3 (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_next;

  assign lvl_next = (s2_reg == s3_reg) ? s2_reg : o_level;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      s1_reg  <= 1'b0;
      s2_reg  <= 1'b0;
      s3_reg  <= 1'b0;
      o_level <= 1'b0;
    end
    else
    begin
      s1_reg  <= i_async;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      o_level <= lvl_next;
    end
  end
endmodule

// file: hw/pdc_channel.sv
// one channel of delimiter handling, collision and carrier signalling
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - half duplex: transmit while receiving non-idle symbols raises collision
// - collision keeps line data flowing; transmit-to-carrier loopback is off
// - carrier holds from collision start until both packets have ended
// - outside collision test, no collision in full duplex, link fail or diagnostic loopback
// - 10M reception follows squelch; at 10M only, receive nibbles are zero during collision
// - 10M: SQE test and jabber also raise collision
// - collision test bit copies transmit enable to collision, line outputs off
// - collision indicator pin goes low 100 ms per collision when selected
// - 100M transmit replaces first two preamble symbols with J K
// - 100M receive checks ten-bit windows; idle keeps carrier and valid low
// - J K while idle starts packet with carrier, valid and 0101 data
// - other window with two separated zeros: false carrier, 1110, error, status
// - after false carrier, an I I pair is needed before a new J K
// - other windows without two separated zeros are dropped while idle
// - 10M: valid squelch data starts packet and raises carrier
// - 100M transmit appends T R right after the last data symbol
// - T R in a packet ends it, dropping carrier and valid, idle data shown
// - I I in a packet: error for one nibble, then all drop, status set
// - 10M: start-of-idle pulse follows the fall of transmit enable
// - 10M: start-of-idle detection ends reception, carrier and valid drop
// - 10M: start-of-idle returns the receiver to squelched state
module pdc_channel #(
  parameter int LED_CYC = pdc_pkg::COL_LED_CYC,
  parameter int LED_W   = $clog2(pdc_pkg::COL_LED_CYC + 1)
) (
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  input  wire logic [3:0]       i_addr,
  input  wire logic [7:0]       i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [7:0]       o_rdata,
  input  wire logic             i_tx_en,
  input  wire logic [3:0]       i_txd,
  input  wire logic             i_link_ok,
  input  wire logic             i_sqe_test,
  input  wire logic             i_jabber,
  input  wire logic [9:0]       i_rx_pair,
  input  wire logic             i_rx_pair_vld,
  input  wire logic [3:0]       i_rx_nibble,
  input  wire logic             i_squelch_ok,
  input  wire logic             i_soi_seen,
  output logic                  o_crs,
  output logic                  o_col,
  output logic                  o_rx_dv,
  output logic                  o_rx_er,
  output logic      [3:0]       o_rxd,
  output pdc_pkg::pdc_txk_t     o_tx_kind,
  output logic      [3:0]       o_tx_nibble,
  output logic                  o_tx_out_en,
  output logic                  o_soi_pulse,
  output logic                  o_col_led_n
);
  import pdc_pkg::*;

  // two zeros with at least one bit between them
  function automatic logic split_zeros(input logic [9:0] w);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
      hit = hit | (~w[i] & (|(~w >> (i + 2))));
    return hit;
  endfunction

  logic [4:0]       ctrl_reg;
  logic [1:0]       stat_reg;
  logic [1:0]       stat_next;
  pdc_rx_t          rx_reg;
  pdc_rx_t          rx_next;
  pdc_txk_t         tx_reg;
  pdc_txk_t         tx_next;
  logic             unsq_reg;
  logic             unsq_next;
  logic             sq_lvl;
  logic             soi_lvl;
  logic             sq_prev_reg;
  logic             soi_prev_reg;
  logic             txen_prev_reg;
  logic             colhold_reg;
  logic             colhold_next;
  logic [4:0]       soi_cnt_reg;
  logic [4:0]       soi_cnt_next;
  logic [LED_W-1:0] led_cnt_reg;
  logic [LED_W-1:0] led_cnt_next;

  pdc_sync3 u_sq (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_squelch_ok),
    .o_level (sq_lvl)
  );

  pdc_sync3 u_soi (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_async (i_soi_seen),
    .o_level (soi_lvl)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register port
  wire sel_ctrl  = i_addr == REG_CTRL;
  wire sel_stat  = i_addr == REG_STAT;
  wire sp100     = ctrl_reg[CTL_SPEED100];
  wire full_dup  = ctrl_reg[CTL_FULL_DUP];
  wire loopback  = ctrl_reg[CTL_LOOPBACK];
  wire col_test  = ctrl_reg[CTL_COL_TEST];
  wire led_sel   = ctrl_reg[CTL_LED_COL];
  wire w1c_stat  = i_wr & sel_stat;

  //////////////////////////////////////////////////////////////////////////////
  // 100M receive window decode
  wire is_ii    = i_rx_pair == PAIR_II;
  wire is_jk    = i_rx_pair == PAIR_JK;
  wire is_tr    = i_rx_pair == PAIR_TR;
  wire is_fc    = ~is_ii & ~is_jk & split_zeros(i_rx_pair);
  wire win      = i_rx_pair_vld & sp100;
  wire ssd_hit  = win & (rx_reg == RX_IDLE) & is_jk;
  wire fc_hit   = win & (rx_reg == RX_IDLE) & is_fc;
  wire prem_hit = win & (rx_reg == RX_PKT) & ~is_tr & is_ii;

  always_comb
  begin
    rx_next = rx_reg;
    unique case (rx_reg)
      RX_IDLE:
      begin
        if (ssd_hit)
          rx_next = RX_PKT;
        else if (fc_hit)
          rx_next = RX_FALSE;
      end
      RX_PKT:
      begin
        if (win & is_tr)
          rx_next = RX_IDLE;
        else if (prem_hit)
          rx_next = RX_PREM;
      end
      RX_FALSE:
      begin
        if (win & is_ii)
          rx_next = RX_IDLE;
      end
      RX_PREM:
        rx_next = RX_IDLE;
    endcase
    if (!sp100)
      rx_next = RX_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // 10M receive: squelch opens the packet, start of idle closes it
  wire sq_rise  = sq_lvl & ~sq_prev_reg;
  wire soi_rise = soi_lvl & ~soi_prev_reg;
  // a new packet needs a fresh squelch opening, so noise after idle is ignored
  assign unsq_next = sp100 ? 1'b0 : soi_rise ? 1'b0 : sq_rise ? 1'b1 : unsq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // 100M transmit delimiters
  always_comb
  begin
    tx_next = tx_reg;
    unique case (tx_reg)
      TXK_IDLE:
        if (i_tx_en & sp100)
          tx_next = TXK_J;
      TXK_J:
        tx_next = TXK_K;
      TXK_K:
        tx_next = i_tx_en ? TXK_DATA : TXK_T;
      TXK_DATA:
        tx_next = i_tx_en ? TXK_DATA : TXK_T;
      TXK_T:
        tx_next = TXK_R;
      TXK_R:
        tx_next = TXK_IDLE;
      default:
        tx_next = TXK_IDLE;
    endcase
    if (!sp100)
      tx_next = i_tx_en ? TXK_DATA : TXK_IDLE;
  end

  wire tx_fall = txen_prev_reg & ~i_tx_en;
  assign soi_cnt_next = (~sp100 & tx_fall) ? 5'(SOI_CYC) :
                        (soi_cnt_reg != 5'h00) ? soi_cnt_reg - 5'h01 : 5'h00;

  //////////////////////////////////////////////////////////////////////////////
  // collision and carrier
  wire tx_busy   = i_tx_en | (sp100 ? (tx_reg != TXK_IDLE) : (soi_cnt_reg != 5'h00));
  wire rx_busy   = sp100 ? (rx_reg != RX_IDLE) : unsq_reg;
  // line outputs are off in collision test, so nothing goes out to collide with
  wire col_allow = ~full_dup & i_link_ok & ~loopback & ~col_test;
  wire col_net   = col_allow & tx_busy & rx_busy;
  wire col_aux   = ~sp100 & col_allow & (i_sqe_test | i_jabber);
  wire col_next  = col_test ? i_tx_en : (col_net | col_aux);
  assign colhold_next = col_net | (colhold_reg & (tx_busy | rx_busy));
  // transmit enable feeds carrier only in half duplex and never during collision
  wire tx_loop   = ~full_dup & i_tx_en & ~col_net & ~colhold_reg;
  wire rx_crs    = sp100 ? (rx_next != RX_IDLE) : unsq_next;
  wire crs_next  = rx_crs | tx_loop | colhold_next;
  wire dv_next   = sp100 ? ((rx_next == RX_PKT) | (rx_next == RX_PREM)) : unsq_next;
  wire er_next   = sp100 & ((rx_next == RX_FALSE) | (rx_next == RX_PREM));

  logic [3:0] rxd_next;
  assign rxd_next = (~sp100 & col_net) ? RXD_ZERO :
                    ssd_hit ? RXD_SSD :
                    (rx_next == RX_FALSE) ? RXD_FC :
                    dv_next ? i_rx_nibble : RXD_ZERO;

  // line outputs are cut during collision test and, at 10M only, during jabber
  wire out_en_next = ~col_test & ~(~sp100 & i_jabber);

  //////////////////////////////////////////////////////////////////////////////
  // collision indicator; retriggers on each new collision
  wire col_start = col_net & ~colhold_reg;
  assign led_cnt_next = col_start ? LED_W'(LED_CYC) :
                        (led_cnt_reg != '0) ? led_cnt_reg - LED_W'(1) : '0;
  wire led_n_next = ~(led_sel & (led_cnt_next != '0));

  assign stat_next[STA_BAD_SSD] = fc_hit |
      (stat_reg[STA_BAD_SSD] & ~(w1c_stat & i_wdata[STA_BAD_SSD]));
  assign stat_next[STA_ESD_ERR] = prem_hit |
      (stat_reg[STA_ESD_ERR] & ~(w1c_stat & i_wdata[STA_ESD_ERR]));

  wire [7:0] rd_word = sel_ctrl ? {3'h0, ctrl_reg} :
                       sel_stat ? {3'h0, dv_next, o_crs, o_col, stat_reg} : 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // state and outputs
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      ctrl_reg      <= CTRL_RST;
      stat_reg      <= 2'h0;
      rx_reg        <= RX_IDLE;
      tx_reg        <= TXK_IDLE;
      unsq_reg      <= 1'b0;
      sq_prev_reg   <= 1'b0;
      soi_prev_reg  <= 1'b0;
      txen_prev_reg <= 1'b0;
      colhold_reg   <= 1'b0;
      soi_cnt_reg   <= 5'h00;
      led_cnt_reg   <= '0;
    end
    else
    begin
      if (i_wr & sel_ctrl)
        ctrl_reg <= i_wdata[4:0];
      stat_reg      <= stat_next;
      rx_reg        <= rx_next;
      tx_reg        <= tx_next;
      unsq_reg      <= unsq_next;
      sq_prev_reg   <= sq_lvl;
      soi_prev_reg  <= soi_lvl;
      txen_prev_reg <= i_tx_en;
      colhold_reg   <= colhold_next;
      soi_cnt_reg   <= soi_cnt_next;
      led_cnt_reg   <= led_cnt_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_rdata     <= 8'h00;
      o_crs       <= 1'b0;
      o_col       <= 1'b0;
      o_rx_dv     <= 1'b0;
      o_rx_er     <= 1'b0;
      o_rxd       <= RXD_ZERO;
      o_tx_kind   <= TXK_IDLE;
      o_tx_nibble <= 4'h0;
      o_tx_out_en <= 1'b1;
      o_soi_pulse <= 1'b0;
      o_col_led_n <= 1'b1;
    end
    else
    begin
      o_rdata     <= i_rd ? rd_word : 8'h00;
      o_crs       <= crs_next;
      o_col       <= col_next;
      o_rx_dv     <= dv_next;
      o_rx_er     <= er_next;
      o_rxd       <= rxd_next;
      o_tx_kind   <= tx_next;
      o_tx_nibble <= (tx_next == TXK_DATA) ? i_txd : 4'h0;
      o_tx_out_en <= out_en_next;
      o_soi_pulse <= soi_cnt_next != 5'h00;
      o_col_led_n <= led_n_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_tx_start;
    sp100 && tx_reg == TXK_IDLE && i_tx_en;
  endsequence

  sequence s_jk_out;
    o_tx_kind == TXK_J ##1 o_tx_kind == TXK_K;
  endsequence

  sequence s_prem_out;
    o_rx_er && o_crs && o_rx_dv ##1 !o_rx_er && !o_rx_dv;
  endsequence

  full_no_col_a: assert property (@(posedge i_clk) disable iff (i_reset)
    full_dup && !col_test |=> !o_col)
    else $error("collision raised in full duplex");

  col_test_a: assert property (@(posedge i_clk) disable iff (i_reset)
    col_test |=> o_col == $past(i_tx_en) && !o_tx_out_en)
    else $error("collision test does not mirror transmit enable");

  tx_ssd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    s_tx_start |=> s_jk_out)
    else $error("start delimiter not sent");

  tx_esd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sp100 && tx_reg == TXK_DATA && !i_tx_en |=> o_tx_kind == TXK_T ##1 o_tx_kind == TXK_R)
    else $error("end delimiter not sent");

  rx_ssd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    ssd_hit |=> o_crs && o_rx_dv && o_rxd == RXD_SSD)
    else $error("start delimiter not reported");

  false_car_a: assert property (@(posedge i_clk) disable iff (i_reset)
    fc_hit |=> o_crs && !o_rx_dv && o_rx_er && o_rxd == RXD_FC && stat_reg[STA_BAD_SSD])
    else $error("false carrier not reported");

  rx_prem_a: assert property (@(posedge i_clk) disable iff (i_reset)
    prem_hit |=> s_prem_out)
    else $error("premature end not reported");

  col_crs_a: assert property (@(posedge i_clk) disable iff (i_reset)
    colhold_reg |-> o_crs)
    else $error("carrier dropped during collision");

  col10_rxd_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !sp100 && col_net |=> o_rxd == RXD_ZERO && o_col)
    else $error("receive data not zero in collision");

  led_low_a: assert property (@(posedge i_clk) disable iff (i_reset)
    col_start && led_sel |=> !o_col_led_n [*8])
    else $error("collision indicator not held low");

  soi_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !sp100 && tx_fall |=> o_soi_pulse [*8])
    else $error("start-of-idle pulse missing");
endmodule

// file: verification/pdc_mac_model.sv
// behavioural MAC controller: the transmit half of the MII feeding the channel
`timescale 1ns/1ps
module pdc_mac_model (
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_send,
  output logic            o_tx_en,
  output logic      [3:0] o_tx_nibble
);
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_tx_en     <= 1'b0;
      o_tx_nibble <= 4'h0;
    end
    else
    begin
      o_tx_en <= i_send;
      // outside a frame the nibble wanders, so a stale value is never mistaken for data
      if (i_send)
        o_tx_nibble <= o_tx_en ? o_tx_nibble + 4'h1 : 4'h0;
      else
        o_tx_nibble <= ~o_tx_nibble;
    end
  end
endmodule

// file: verification/phy_packet_delimit_collision_tb.sv
// self-checking bench for one delimiter and collision channel
`timescale 1ns/1ps
module phy_packet_delimit_collision_tb;
  import pdc_pkg::*;
  localparam int LED_N = 20;
  logic       i_clk, i_reset, wr, rd, link_ok, sqe, jab, rx_vld, squelch, soi, send;
  logic       tx_en, crs, col, dv, er, tx_oe, soi_p, led_n;
  logic [3:0] addr, rx_nib, txd, rxd, tx_nib;
  logic [7:0] wdata, rdata;
  logic [9:0] rx_pair;
  pdc_txk_t   kind, ek;
  int         miscompares, checks, n;
  logic [9:0] drop[2] = '{10'h3FE, 10'h3F3};
  logic [8:0] cfg[3]  = '{9'h103, 9'h105, 9'h001};

  pdc_channel #(.LED_CYC(LED_N), .LED_W(5)) u_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_tx_en(tx_en), .i_txd(txd), .i_link_ok(link_ok),
    .i_sqe_test(sqe), .i_jabber(jab), .i_rx_pair(rx_pair), .i_rx_pair_vld(rx_vld),
    .i_rx_nibble(rx_nib), .i_squelch_ok(squelch), .i_soi_seen(soi), .o_crs(crs),
    .o_col(col), .o_rx_dv(dv), .o_rx_er(er), .o_rxd(rxd), .o_tx_kind(kind),
    .o_tx_nibble(tx_nib), .o_tx_out_en(tx_oe), .o_soi_pulse(soi_p), .o_col_led_n(led_n));

  pdc_mac_model u_mac (.i_clk(i_clk), .i_reset(i_reset), .i_send(send),
    .o_tx_en(tx_en), .o_tx_nibble(txd));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask

  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // a window is one cycle wide; the lines then carry junk so nothing stale is reused
  task automatic win(input logic [9:0] v);
    @(posedge i_clk);
    rx_pair <= v;
    rx_vld  <= 1'b1;
    @(posedge i_clk);
    rx_vld  <= 1'b0;
    rx_pair <= ~v;
    #1;
  endtask

  task automatic tx(input logic v);
    @(posedge i_clk);
    send <= v;
  endtask

  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  initial
  begin
    #100000;
    miscompares++;
    finish_test();
  end

  initial
  begin
    {i_reset, link_ok} = 2'b11;
    {wr, rd, sqe, jab, rx_vld, squelch, soi, send} = 8'h00;
    {addr, wdata, rx_nib, rx_pair} = {4'h0, 8'h00, 4'hA, PAIR_II};
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    cyc(1);
    chk({crs, dv}, 8'h00);
    rd_chk(REG_CTRL, {3'h0, CTRL_RST});
    rd_chk(4'h8, 8'h00);
    win(PAIR_JK);
    chk({crs, dv, er, 1'b0, rxd}, {4'hC, RXD_SSD});
    cyc(1);
    chk({crs, dv, er, 1'b0, rxd}, 8'hCA);
    win(PAIR_TR);
    chk({crs, dv, er, 1'b0, rxd}, 8'h00);
    foreach (drop[i])
    begin
      win(drop[i]);
      chk({crs, dv, er}, 8'h00);
    end
    win(10'h3B7);
    chk({crs, dv, er, 1'b0, rxd}, {4'hA, RXD_FC});
    rd_chk(REG_STAT, 8'h09);
    win(PAIR_JK);
    chk({crs, dv, er, 1'b0, rxd}, {4'hA, RXD_FC});
    win(PAIR_II);
    chk({crs, er}, 8'h00);
    win(PAIR_JK);
    win(PAIR_II);
    chk({crs, dv, er}, 8'h07);
    cyc(1);
    chk({crs, dv, er}, 8'h00);
    rd_chk(REG_STAT, 8'h03);
    bus_wr(REG_STAT, 8'h03);
    rd_chk(REG_STAT, 8'h00);
    // transmit framing: six cycles of enable give J K four data T R
    n = 0;
    tx(1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge i_clk);
      if (i == 5)
        send <= 1'b0;
      #1;
      if (kind !== TXK_IDLE)
      begin
        ek = (n == 0) ? TXK_J : (n == 1) ? TXK_K : (n < 6) ? TXK_DATA : (n == 6) ? TXK_T : TXK_R;
        chk({5'h00, kind}, {5'h00, ek});
        if (ek == TXK_DATA)
          chk({4'h0, tx_nib}, n[7:0]);
        n++;
      end
    end
    chk(n[7:0], 8'h08);
    // half duplex collision: receive first, then transmit over it
    win(PAIR_JK);
    tx(1'b1);
    cyc(5);
    chk({col, crs}, 8'h03);
    chk({1'b0, kind, rxd}, {1'b0, TXK_DATA, 4'hA});
    win(PAIR_TR);
    cyc(2);
    chk({col, crs}, 8'h01);
    tx(1'b0);
    cyc(8);
    chk({col, crs}, 8'h00);
    foreach (cfg[i])
    begin
      bus_wr(REG_CTRL, cfg[i][7:0]);
      @(posedge i_clk);
      link_ok <= cfg[i][8];
      win(PAIR_JK);
      tx(1'b1);
      cyc(5);
      chk({7'h00, col}, 8'h00);
      tx(1'b0);
      win(PAIR_TR);
      cyc(8);
    end
    @(posedge i_clk);
    link_ok <= 1'b1;
    bus_wr(REG_CTRL, 8'h09);
    cyc(1);
    chk({7'h00, tx_oe}, 8'h00);
    tx(1'b1);
    cyc(4);
    chk({col, tx_oe}, 8'h02);
    tx(1'b0);
    cyc(4);
    chk({col, tx_oe}, 8'h00);
    bus_wr(REG_CTRL, 8'h11);
    chk({7'h00, led_n}, 8'h01);
    win(PAIR_JK);
    tx(1'b1);
    for (int i = 0; i < 10 && led_n !== 1'b0; i++)
      cyc(1);
    n = 0;
    while (led_n === 1'b0 && n < 100)
    begin
      cyc(1);
      n++;
    end
    chk(n[7:0], LED_N);
    tx(1'b0);
    win(PAIR_TR);
    cyc(8);
    // 10 Mbps: squelch carries reception, start-of-idle ends it
    bus_wr(REG_CTRL, 8'h00);
    @(posedge i_clk);
    squelch <= 1'b1;
    cyc(6);
    chk({crs, dv}, 8'h03);
    tx(1'b1);
    cyc(5);
    chk({col, rxd}, 8'h10);
    tx(1'b0);
    n = 0;
    for (int i = 0; i < 30; i++)
    begin
      cyc(1);
      if (soi_p === 1'b1)
        n++;
    end
    chk(n[7:0], SOI_CYC);
    @(posedge i_clk);
    soi <= 1'b1;
    cyc(6);
    chk({crs, dv}, 8'h00);
    @(posedge i_clk);
    soi <= 1'b0;
    cyc(6);
    chk({crs, dv}, 8'h00);
    @(posedge i_clk);
    squelch <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge i_clk);
      {sqe, jab} <= (i == 0) ? 2'b10 : 2'b01;
      cyc(6);
      chk({7'h00, col}, 8'h01);
      @(posedge i_clk);
      {sqe, jab} <= 2'b00;
      cyc(6);
      chk({7'h00, col}, 8'h00);
    end
    finish_test();
  end
endmodule
